// file: mce_cfg.svh
// Purpose: constants of the machine-check error banks
// Assumes: included by mce_pkg.sv and by the bank module
// Notes:   offsets are byte addresses on the 32-bit register bus
`ifndef BANK_CFG_SVH
`define BANK_CFG_SVH
// ******************************
// status word layout
// ******************************
`define ST_VAL 63
`define ST_OVF 62
`define ST_UC 61
`define ST_AV 58
`define ST_PCC 57
`define ST_MT 17
`define ST_HF 16
// ******************************
// register offsets
// ******************************
`define A_B0_LO 8'h00
`define A_B0_HI 8'h04
`define A_B1_LO 8'h08
`define A_B1_HI 8'h0c
`define A_B2_LO 8'h10
`define A_B2_HI 8'h14
`define A_B1_ADDR 8'h18
`define A_B2_CTL 8'h1c
`define A_CTRL 8'h20
`define A_IRQ_ST 8'h24
`define A_IRQ_CLR 8'h28
`define A_IRQ_EN 8'h2c
`define A_BANK_CLR 8'h30
`define A_SEQ_ST 8'h34
// ******************************
// widths, reset values, answers
// ******************************
`define B2EN_W 8
`define B2EN_RST 8'hff
`define QID_W 3
`define QDEPTH 8
`define RESP_OK 2'b00
`define RESP_SLVERR 2'b10
`endif

// file: mce_pkg.sv
// Purpose: types of the machine-check error banks
// Assumes: mce_cfg.svh holds the numbers
// Notes:   the whole module state is one packed struct
`include "mce_cfg.svh"
package bank_pkg;
  typedef enum logic [1:0] {SG_RUN, SG_ENTER, SG_WAIT, SG_HOLD} sg_state_t;
  typedef struct packed {
    logic [63:0]             st0;
    logic [63:0]             st1;
    logic [63:0]             st2;
    logic [31:0]             addr1;
    logic [`B2EN_W-1:0]      b2en;
    logic                    mc_en;
    logic [3:0]              irq_st;
    logic [3:0]              irq_en;
    logic                    irq;
    logic [31:0]             poison_addr;
    logic                    poison_v;
    logic [`QDEPTH-1:0]      defq;
    logic                    remove;
    logic [`QID_W-1:0]       remove_id;
    logic                    exc;
    logic                    in_handler;
    logic                    mgi_pend;
    logic                    mgi_take;
    sg_state_t               sg;
    logic                    sg_out;
    logic                    sg_ack;
    logic [1:0]              init_cnt;
    logic                    init_done;
    logic                    stp_s1;
    logic                    stp_s2;
    logic                    mgi_s1;
    logic                    mgi_s2;
    logic                    mgi_s3;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
  } state_t;
endpackage

// file: mce_banks.sv
// Purpose: machine-check error banks, exception ordering and stop-grant
// Assumes: error event inputs come from logic on ref_clk; pins are synchronised
// Notes:   registers reached over AXI4-Lite
// Function
// - a deferred transaction that later hard-fails is dropped from the bus queue
// - prefetch tag error sets uncorrectable and context-corrupt, exception on later access when reported for bank 0
// - bank 2 with all enables clear still logs uncorrectable errors, no exception
// - bank 1 address holds the address of the error itself
// - errors in both sector halves log twice: valid and overflow in banks 0 and 1
// - overflow sets on any error logged while valid is set
// - after an uncorrectable log only the error code field and the overflow bit change
// - speculative correctable bank 1 error leaves bank 1 status unchanged
// - bank 1 address-valid only when the error address is valid
// - code fetch hard-failure marks hard-failure in bank 0 status
// - corrupted port I/O data raises the exception when enabled
// - exception beats a simultaneous management interrupt, which stays pending
// - banks are cleared in a walk after reset release
// - ownership request matching several tags logs a multiple-tag-match error, flagged in bank 0 status only
// - stop-clock enters stop-grant state, then issues the acknowledge cycle
`include "mce_cfg.svh"
module machine_check_error_banks
  import bank_pkg::*;
(
  input  wire logic               ref_clk,              // core clock
  input  wire logic               reset,                // sync reset
  input  wire logic               err_valid,            // error report pulse
  input  wire logic [1:0]         err_bank,             // bank of the error
  input  wire logic [15:0]        err_code,             // error code
  input  wire logic               err_uncorr,           // uncorrectable
  input  wire logic               err_ctx_corrupt,      // context corrupt
  input  wire logic               err_prefetch,         // from hw prefetch
  input  wire logic               err_speculative,      // speculative load
  input  wire logic               err_addr_ok,          // address is valid
  input  wire logic [31:0]        err_addr,             // physical address
  input  wire logic               err_both_halves,      // both sector halves
  input  wire logic               err_multi_tag,        // multiple tag match
  input  wire logic               err_hard_fail,        // hard-failure reply
  input  wire logic               io_data_corrupt,      // port I/O data bad
  input  wire logic               access_valid,         // cache access pulse
  input  wire logic [31:0]        access_addr,          // its address
  input  wire logic               bus_defer_valid,      // deferred in snoop
  input  wire logic [`QID_W-1:0]  bus_defer_id,         // its queue slot
  input  wire logic               bus_hard_fail_valid,  // hard-failure reply
  input  wire logic [`QID_W-1:0]  bus_hard_fail_id,     // its queue slot
  input  wire logic               handler_done,         // handler completed
  input  wire logic               stop_clock_n,         // stop-clock pin
  input  wire logic               system_mgmt_interrupt_n, // mgmt int pin
  output logic                    machine_check_exception, // exception pulse
  output logic                    mgi_taken,            // mgmt int delivered
  output logic                    stop_grant_state,     // in stop-grant
  output logic                    stop_grant_ack,       // ack cycle pulse
  output logic                    bus_queue_remove,     // slot drop pulse
  output logic [`QID_W-1:0]       bus_queue_remove_id,  // slot dropped
  output logic                    irq,                  // level interrupt
  input  wire logic [7:0]         s_axi_awaddr,         // write address
  input  wire logic               s_axi_awvalid,        // write addr valid
  output logic                    s_axi_awready,        // write addr ready
  input  wire logic [31:0]        s_axi_wdata,          // write data
  input  wire logic [3:0]         s_axi_wstrb,          // byte enables
  input  wire logic               s_axi_wvalid,         // write data valid
  output logic                    s_axi_wready,         // write data ready
  output logic [1:0]              s_axi_bresp,          // write response
  output logic                    s_axi_bvalid,         // response valid
  input  wire logic               s_axi_bready,         // response ready
  input  wire logic [7:0]         s_axi_araddr,         // read address
  input  wire logic               s_axi_arvalid,        // read addr valid
  output logic                    s_axi_arready,        // read addr ready
  output logic [31:0]             s_axi_rdata,          // read data
  output logic [1:0]              s_axi_rresp,          // read response
  output logic                    s_axi_rvalid,         // read data valid
  input  wire logic               s_axi_rready          // read data ready
);

  // ******************************
  // bank logging
  // ******************************
  function automatic logic [63:0] log_err(input logic [63:0] s, input logic [15:0] code,
                                          input logic uc, input logic pcc, input logic av,
                                          input logic hf, input logic mt);
    logic [63:0] v;
    v = s;
    if (!s[`ST_VAL]) begin
      v = '0;
      v[`ST_VAL] = 1'b1;
      v[`ST_UC] = uc;
      v[`ST_PCC] = pcc;
      v[`ST_AV] = av;
      v[`ST_HF] = hf;
      v[`ST_MT] = mt;
      v[15:0] = code;
    end else begin
      v[`ST_OVF] = 1'b1;
      v[15:0] = code;
      if (!s[`ST_UC] && uc) begin
        v[`ST_UC] = 1'b1;
        v[`ST_PCC] = pcc;
        v[`ST_AV] = av;
        v[`ST_HF] = hf;
        v[`ST_MT] = mt;
      end
    end
    return v;
  endfunction

  state_t s;
  state_t n;
  logic   act;
  logic   exc_raise;
  logic   poison_hit;
  logic   log0;
  logic   log1;
  logic   log2;
  logic   def_hit;
  logic   pcc_in;
  logic   wr_go;
  logic   rd_go;

  assign act        = err_valid & s.init_done;
  assign pcc_in     = err_ctx_corrupt | (err_prefetch & err_uncorr);
  assign poison_hit = access_valid & s.poison_v & (access_addr == s.poison_addr);
  assign exc_raise  = s.mc_en & s.init_done &
                      ((act & err_uncorr & !err_prefetch &
                        !(err_bank == 2'd2 && s.b2en == '0)) |
                       io_data_corrupt | poison_hit);
  assign log0       = act & (err_bank == 2'd0 | err_both_halves);
  assign log1       = act & (err_bank == 2'd1 | err_both_halves) &
                      !(err_speculative & !err_uncorr);
  assign log2       = act & (err_bank == 2'd2);
  assign def_hit    = bus_hard_fail_valid & s.defq[bus_hard_fail_id];
  assign wr_go      = s.awready & s_axi_awvalid & s.wready & s_axi_wvalid;
  assign rd_go      = s.arready & s_axi_arvalid;

  always_comb begin
    n = s;
    n.stp_s1 = stop_clock_n;
    n.stp_s2 = s.stp_s1;
    n.mgi_s1 = system_mgmt_interrupt_n;
    n.mgi_s2 = s.mgi_s1;
    n.mgi_s3 = s.mgi_s2;
    n.remove = 1'b0;
    n.exc = 1'b0;
    n.mgi_take = 1'b0;
    n.sg_ack = 1'b0;

    // ******************************
    // clearing walk after reset
    // ******************************
    if (!s.init_done) begin
      case (s.init_cnt)
        2'd0: n.st0 = '0;
        2'd1: n.st1 = '0;
        default: begin
          n.st2 = '0;
          n.addr1 = '0;
          n.init_done = 1'b1;
        end
      endcase
      n.init_cnt = s.init_cnt + 2'd1;
    end

    // ******************************
    // register bus
    // ******************************
    if (!s.awready && !s.bvalid && s_axi_awvalid && s_axi_wvalid) begin
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.awready = 1'b0;
      n.wready = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OK;
      case (s_axi_awaddr)
        `A_B0_LO, `A_B0_HI, `A_B1_LO, `A_B1_HI, `A_B2_LO, `A_B2_HI,
        `A_B1_ADDR, `A_IRQ_ST, `A_SEQ_ST: ;
        `A_B2_CTL: if (s_axi_wstrb[0]) n.b2en = s_axi_wdata[`B2EN_W-1:0];
        `A_CTRL: if (s_axi_wstrb[0]) n.mc_en = s_axi_wdata[0];
        `A_IRQ_CLR: if (s_axi_wstrb[0]) n.irq_st = s.irq_st & ~s_axi_wdata[3:0];
        `A_IRQ_EN: if (s_axi_wstrb[0]) n.irq_en = s_axi_wdata[3:0];
        `A_BANK_CLR: begin
          if (s_axi_wstrb[0] && s_axi_wdata[0]) n.st0 = '0;
          if (s_axi_wstrb[0] && s_axi_wdata[1]) n.st1 = '0;
          if (s_axi_wstrb[0] && s_axi_wdata[2]) n.st2 = '0;
        end
        default: n.bresp = `RESP_SLVERR;
      endcase
    end
    if (!s.arready && !s.rvalid && s_axi_arvalid) begin
      n.arready = 1'b1;
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = `RESP_OK;
      case (s_axi_araddr)
        `A_B0_LO: n.rdata = s.st0[31:0];
        `A_B0_HI: n.rdata = s.st0[63:32];
        `A_B1_LO: n.rdata = s.st1[31:0];
        `A_B1_HI: n.rdata = s.st1[63:32];
        `A_B2_LO: n.rdata = s.st2[31:0];
        `A_B2_HI: n.rdata = s.st2[63:32];
        `A_B1_ADDR: n.rdata = s.addr1;
        `A_B2_CTL: n.rdata = {24'h0, s.b2en};
        `A_CTRL: n.rdata = {31'h0, s.mc_en};
        `A_IRQ_ST: n.rdata = {28'h0, s.irq_st};
        `A_IRQ_EN: n.rdata = {28'h0, s.irq_en};
        `A_IRQ_CLR, `A_BANK_CLR: n.rdata = 32'h0;
        `A_SEQ_ST: n.rdata = {16'h0, s.defq, 2'b00, s.sg, s.mgi_pend,
                              s.in_handler, s.poison_v, s.init_done};
        default: begin
          n.rdata = 32'h0;
          n.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // ******************************
    // error logging, after bank clear so a new error wins
    // ******************************
    if (log1 && !n.st1[`ST_VAL] && err_addr_ok) begin
      n.addr1 = err_addr;
    end
    if (log0) begin
      n.st0 = log_err(n.st0, err_code, err_uncorr, pcc_in, err_addr_ok,
                      err_hard_fail, err_multi_tag);
    end
    if (log0 && err_both_halves) begin
      n.st0 = log_err(n.st0, err_code, err_uncorr, pcc_in, err_addr_ok,
                      err_hard_fail, err_multi_tag);
    end
    if (log1) begin
      n.st1 = log_err(n.st1, err_code, err_uncorr, pcc_in, err_addr_ok, 1'b0, 1'b0);
    end
    if (log1 && err_both_halves) begin
      n.st1 = log_err(n.st1, err_code, err_uncorr, pcc_in, err_addr_ok, 1'b0, 1'b0);
    end
    if (log2) begin
      n.st2 = log_err(n.st2, err_code, err_uncorr, pcc_in, err_addr_ok, 1'b0, 1'b0);
    end

    // ******************************
    // poisoned prefetch location
    // ******************************
    if (poison_hit) begin
      n.poison_v = 1'b0;
    end
    if (act && err_prefetch && err_uncorr && err_bank == 2'd0) begin
      n.poison_v = 1'b1;
      n.poison_addr = err_addr;
    end

    // ******************************
    // exception and management interrupt
    // ******************************
    if (handler_done) begin
      n.in_handler = 1'b0;
    end
    if (exc_raise) begin
      n.exc = 1'b1;
      n.in_handler = 1'b1;
    end
    if (!s.mgi_s2 && s.mgi_s3) begin
      n.mgi_pend = 1'b1;
    end
    if (s.mgi_pend && !s.in_handler && !s.exc && !exc_raise) begin
      n.mgi_take = 1'b1;
      n.mgi_pend = !s.mgi_s2 && s.mgi_s3;
    end

    // ******************************
    // bus queue
    // ******************************
    if (def_hit) begin
      n.defq[bus_hard_fail_id] = 1'b0;
      n.remove = 1'b1;
      n.remove_id = bus_hard_fail_id;
    end
    if (bus_defer_valid) begin
      n.defq[bus_defer_id] = 1'b1;
    end

    // ******************************
    // stop-grant sequence
    // ******************************
    case (s.sg)
      SG_RUN: if (!s.stp_s2) n.sg = SG_ENTER;
      SG_ENTER: n.sg = SG_WAIT;
      SG_WAIT: begin
        if (!s.in_handler && !s.exc && !exc_raise) begin
          n.sg = SG_HOLD;
          n.sg_ack = 1'b1;
        end
      end
      SG_HOLD: if (s.stp_s2) n.sg = SG_RUN;
      default: n.sg = SG_RUN;
    endcase
    n.sg_out = (n.sg != SG_RUN);

    // ******************************
    // interrupt: set wins over clear
    // ******************************
    n.irq_st = n.irq_st | {n.remove, n.sg_ack, n.exc, log0 | log1 | log2};
    n.irq = |(n.irq_st & n.irq_en);

    if (reset) begin
      n = '0;
      n.b2en = `B2EN_RST;
      n.stp_s1 = 1'b1;
      n.stp_s2 = 1'b1;
      n.mgi_s1 = 1'b1;
      n.mgi_s2 = 1'b1;
      n.mgi_s3 = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= n;
  end

  assign machine_check_exception = s.exc;
  assign mgi_taken               = s.mgi_take;
  assign stop_grant_state        = s.sg_out;
  assign stop_grant_ack          = s.sg_ack;
  assign bus_queue_remove        = s.remove;
  assign bus_queue_remove_id     = s.remove_id;
  assign irq                     = s.irq;
  assign s_axi_awready           = s.awready;
  assign s_axi_wready            = s.wready;
  assign s_axi_bvalid            = s.bvalid;
  assign s_axi_bresp             = s.bresp;
  assign s_axi_arready           = s.arready;
  assign s_axi_rvalid            = s.rvalid;
  assign s_axi_rresp             = s.rresp;
  assign s_axi_rdata             = s.rdata;

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  queue_drop_a: assert property (def_hit && !bus_defer_valid |=>
    bus_queue_remove && !s.defq[$past(bus_hard_fail_id)]) else $error("slot not dropped");
  b2_quiet_a: assert property (log2 && err_uncorr && s.b2en == '0 && !io_data_corrupt
    && !poison_hit |=> !machine_check_exception && s.st2[`ST_VAL]) else $error("bank2 quiet");
  addr_keep_a: assert property (log1 && !s.st1[`ST_VAL] && err_addr_ok && !wr_go
    |=> s.addr1 == $past(err_addr) && s.st1[`ST_AV]) else $error("bank1 address wrong");
  both_halves_a: assert property (log0 && log1 && err_both_halves
    |=> s.st0[`ST_OVF] && s.st1[`ST_OVF] && s.st1[`ST_VAL]) else $error("no double log");
  ovf_set_a: assert property (log0 && s.st0[`ST_VAL] && !wr_go
    |=> s.st0[`ST_OVF]) else $error("overflow missed");
  uc_hold_a: assert property (log0 && s.st0[`ST_UC] && !wr_go
    |=> s.st0[61:16] == $past(s.st0[61:16])) else $error("fields changed");
  spec_keep_a: assert property (act && err_speculative && !err_uncorr && err_bank == 2'd1
    && !err_both_halves && !wr_go |=> $stable(s.st1)) else $error("speculative log");
  av_clear_a: assert property (log1 && !s.st1[`ST_VAL] && !err_addr_ok && !wr_go
    |=> !s.st1[`ST_AV]) else $error("address valid set");
  exc_first_a: assert property (exc_raise && s.mgi_pend
    |=> machine_check_exception && !mgi_taken && s.mgi_pend) else $error("mgmt int first");
  init_walk_a: assert property ($fell(reset) |-> !s.init_done ##3 s.init_done
    && s.st0 == '0) else $error("clear walk");
  sg_order_a: assert property (!s.stp_s2 && s.sg == SG_RUN |=> stop_grant_state
    && !stop_grant_ack) else $error("stop grant entry");
  ack_after_a: assert property (stop_grant_ack |-> !s.in_handler && !s.exc)
    else $error("ack during handler");
  first_load_a: assert property (log2 && !s.st2[`ST_VAL] && !wr_go
    |=> s.st2[`ST_VAL] && !s.st2[`ST_OVF]) else $error("first load wrong");

endmodule

// file: bus_agent.sv
// Purpose: chipset side of the system bus, driven by bench commands
// Assumes: commands arrive just after a rising edge of ref_clk
// Notes:   idle slot ids toggle so a stale id is never mistaken for a live one
module bus_agent (
  input  wire logic       ref_clk,                 // core clock
  input  wire logic       reset,                   // sync reset
  input  wire logic       defer_req,               // defer a slot
  input  wire logic       fail_req,                // hard-fail a slot
  input  wire logic [2:0] slot_req,                // slot of the request
  input  wire logic       stop_req,                // ask for stop-grant
  input  wire logic       mgi_req,                 // raise mgmt interrupt
  input  wire logic       stop_grant_ack,          // ack cycle seen
  output logic            bus_defer_valid,         // defer pulse
  output logic [2:0]      bus_defer_id,            // its slot
  output logic            bus_hard_fail_valid,     // hard-fail pulse
  output logic [2:0]      bus_hard_fail_id,        // its slot
  output logic            stop_clock_n,            // stop-clock pin
  output logic            system_mgmt_interrupt_n, // mgmt interrupt pin
  output logic            ignoring                 // processor traffic ignored
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      {bus_defer_valid, bus_hard_fail_valid, ignoring} <= '0;
      {bus_defer_id, bus_hard_fail_id} <= '0;
      {stop_clock_n, system_mgmt_interrupt_n} <= 2'b11;
    end else begin
      bus_defer_valid <= defer_req && !ignoring;
      bus_hard_fail_valid <= fail_req && !ignoring;
      bus_defer_id <= defer_req ? slot_req : ~bus_defer_id;
      bus_hard_fail_id <= fail_req ? slot_req : ~bus_hard_fail_id;
      stop_clock_n <= !stop_req;
      system_mgmt_interrupt_n <= !mgi_req;
      ignoring <= stop_req && (ignoring || stop_grant_ack);
    end
  end
endmodule

// file: machine_check_error_banks_tb.sv
// Purpose: self-checking bench of the machine-check banks
// Assumes: bus_agent stands on the system bus side
// Notes:   register reads are noted in a queue and checked when data returns
`include "mce_cfg.svh"
module machine_check_error_banks_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, err_valid, err_uncorr, err_ctx_corrupt, err_prefetch, err_speculative;
  logic err_addr_ok, err_both_halves, err_multi_tag, err_hard_fail, io_data_corrupt;
  logic access_valid, handler_done, machine_check_exception, mgi_taken, stop_grant_state;
  logic stop_grant_ack, bus_queue_remove, irq, bus_defer_valid, bus_hard_fail_valid;
  logic stop_clock_n, system_mgmt_interrupt_n, defer_req, fail_req, stop_req, mgi_req, ignoring;
  logic [1:0]  err_bank, s_axi_bresp, s_axi_rresp;
  logic [15:0] err_code;
  logic [31:0] err_addr, access_addr, s_axi_wdata, s_axi_rdata;
  logic [2:0]  bus_queue_remove_id, bus_defer_id, bus_hard_fail_id, slot_req;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] notes[$];
  logic [15:0] c, c1;
  int          n_errors, samples_checked, n_exc, n_mgi, n_ack, n_rm, cyc;
  machine_check_error_banks machine_check_error_banks_inst (.*);
  bus_agent bus_agent_inst (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ******************************
  // output watcher
  // ******************************
  always @(posedge ref_clk) begin
    cyc++;
    n_exc += (machine_check_exception === 1'b1);
    n_mgi += (mgi_taken === 1'b1);
    n_ack += (stop_grant_ack === 1'b1);
    n_rm += (bus_queue_remove === 1'b1);
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      check("read", {s_axi_rresp, s_axi_rdata}, notes.pop_front());
    if (cyc == 6000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do @(posedge ref_clk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    notes.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
  endtask
  // flags: both halves, uncorr, prefetch, speculative, addr ok, hard fail, multi tag
  task automatic err(input logic [1:0] b, input logic [6:0] f, input logic [31:0] a);
    c = 16'($urandom);
    err_valid <= 1'b1;
    err_bank <= b;
    {err_both_halves, err_uncorr, err_prefetch, err_speculative} <= f[6:3];
    {err_addr_ok, err_hard_fail, err_multi_tag} <= f[2:0];
    err_ctx_corrupt <= f[4];
    err_code <= c;
    err_addr <= a;
    @(posedge ref_clk);
    err_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  // w: port I/O corrupt, cache access, handler done
  task automatic pulse(input logic [2:0] w, input int wait_n);
    {io_data_corrupt, access_valid, handler_done} <= w;
    @(posedge ref_clk);
    {io_data_corrupt, access_valid, handler_done} <= 3'b000;
    repeat (wait_n) @(posedge ref_clk);
  endtask
  // ******************************
  // main sequence
  // ******************************
  initial begin
    {err_valid, err_bank, err_code, err_uncorr, err_ctx_corrupt, err_prefetch} = '0;
    {err_speculative, err_addr_ok, err_addr, err_both_halves, err_multi_tag} = '0;
    {err_hard_fail, io_data_corrupt, access_valid, access_addr, handler_done} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, defer_req, fail_req, slot_req} = '0;
    {stop_req, mgi_req} = '0;
    s_axi_wstrb = 4'hf;
    reset = 1'b1;
    void'($urandom(32'h1bb6));
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(`A_B0_HI, 0);
    rd(`A_B1_ADDR, 0);
    rd(8'h3c, {`RESP_SLVERR, 32'h0});
    pulse(3'b100, 3);
    check("exc disabled", n_exc, 0);
    wr(`A_CTRL, 1);
    wr(`A_IRQ_EN, 32'hf);
    err(0, 7'h22, 0);
    check("exc uncorr", n_exc, 1);
    rd(`A_B0_LO, {16'h0001, c});
    rd(`A_B0_HI, 32'ha000_0000);
    err(0, 7'h01, 0);
    rd(`A_B0_LO, {16'h0001, c});
    rd(`A_B0_HI, 32'he000_0000);
    wr(`A_B2_CTL, 0);
    err(2, 7'h20, 0);
    check("exc bank2", n_exc, 1);
    rd(`A_B2_HI, 32'ha000_0000);
    err(1, 7'h04, 32'h1000_0040);
    err(1, 7'h04, 32'h2000_0080);
    c1 = c;
    rd(`A_B1_ADDR, 32'h1000_0040);
    err(1, 7'h08, 0);
    rd(`A_B1_HI, 32'hc400_0000);
    rd(`A_B1_LO, {16'h0, c1});
    wr(`A_BANK_CLR, 2);
    err(1, 7'h00, 32'h3000_0000);
    rd(`A_B1_HI, 32'h8000_0000);
    wr(`A_BANK_CLR, 3);
    err(0, 7'h40, 0);
    rd(`A_B0_HI, 32'hc000_0000);
    rd(`A_B1_HI, 32'hc000_0000);
    wr(`A_BANK_CLR, 1);
    err(0, 7'h01, 0);
    rd(`A_B0_LO, {16'h0002, c});
    wr(`A_BANK_CLR, 1);
    err(0, 7'h30, 32'h0000_5500);
    check("exc prefetch", n_exc, 1);
    rd(`A_B0_HI, 32'ha200_0000);
    access_addr <= 32'h0000_5500;
    pulse(3'b010, 3);
    check("exc later access", n_exc, 2);
    pulse(3'b001, 2);
    mgi_req <= 1'b1;
    // pin sync and edge detect: pending lands with the port I/O error
    repeat (4) @(posedge ref_clk);
    pulse(3'b100, 12);
    check("exc io", n_exc, 3);
    check("mgi held", n_mgi, 0);
    pulse(3'b001, 4);
    check("mgi later", n_mgi, 1);
    mgi_req <= 1'b0;
    {defer_req, slot_req} <= 4'hf;
    @(posedge ref_clk);
    {defer_req, fail_req} <= 2'b01;
    @(posedge ref_clk);
    {fail_req, slot_req} <= 4'ha;
    @(posedge ref_clk);
    fail_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("queue drops", n_rm, 1);
    check("queue id", bus_queue_remove_id, 7);
    err(0, 7'h20, 0);
    stop_req <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check("stop state", stop_grant_state, 1);
    check("ack held", n_ack, 0);
    pulse(3'b001, 4);
    check("ack after handler", n_ack, 1);
    stop_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(`A_IRQ_ST, 32'hf);
    check("irq level", irq, 1);
    wr(`A_IRQ_CLR, 32'hf);
    wr(`A_IRQ_EN, 0);
    err(0, 7'h00, 0);
    check("irq masked", irq, 0);
    rd(`A_IRQ_ST, 32'h1);
    conclude();
  end
endmodule
